// *** hw/ddoc_pkg.sv ***
package ddoc_pkg;

  // register offsets from the board base, word-wide writes only
  localparam logic [7:0] ADDR_CH0_CODE = 8'h10;
  localparam logic [7:0] ADDR_CH1_CODE = 8'h12;

  // code field inside a data word
  localparam int CODE_W = 12;
  localparam int CODE_MSB = 11;
  localparam int WORD_W = 16;

  // serial frame layout: 16 bits, msb first
  localparam int SER_FRAME_BITS = 16;
  localparam int SER_CHAN_BIT = 12;
  localparam logic [4:0] SER_CNT_FULL = 5'h10;

  // mode configuration field codes
  localparam logic [1:0] MODE_FIELD_IMM = 2'h0;
  localparam logic [1:0] MODE_FIELD_FIFO = 2'h1;
  localparam logic [1:0] MODE_FIELD_SER = 2'h2;

  // output fifo shape
  localparam int FIFO_DEPTH = 8;

  // reset values
  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [4:0] SER_CNT_RST = 5'h00;

  // transfer method, one-hot
  typedef enum logic [2:0] {
    DDOC_IMM = 3'b001,
    DDOC_FIFO = 3'b010,
    DDOC_SER = 3'b100
  } ddoc_mode_t;

  // one bus write as seen by the block
  typedef struct packed {
    logic wr;
    logic word;
    logic [7:0] addr;
    logic [15:0] data;
  } ddoc_bus_wr_t;

  // a code tagged with its channel
  typedef struct packed {
    logic chan;
    logic [11:0] code;
  } ddoc_word_t;

endpackage

// *** hw/ddoc_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for a group of pin levels
module ddoc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta_q <= rst_val;
      pin_sync <= rst_val;
    end
    else
    begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule // ddoc_sync

// *** hw/ddoc_fifo.sv ***
`timescale 1ns/1ps
// small synchronous fifo with valid/ready on both sides
module ddoc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // handshake and flags
  assign full = (count_q == (AW+1)'(DEPTH));
  assign empty = (count_q == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  // storage
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule // ddoc_fifo

// *** hw/ddoc_top.sv ***
`timescale 1ns/1ps
module ddoc_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire ddoc_pkg::ddoc_bus_wr_t bus_wr,
  output logic bus_ready,
  input wire logic [1:0] mode_field,
  input wire logic [1:0] ch_bipolar,
  input wire logic update_strobe,
  input wire logic timer_trigger_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_frame_n,
  output logic [23:0] dac_code,
  output logic [1:0] dac_load,
  output logic [1:0] held_pending,
  output logic fifo_full,
  output logic fifo_empty,
  output logic [2:0] mode_state
);

  localparam int NCH = 2;
  localparam int CW = ddoc_pkg::CODE_W;

  // converter-facing form: bipolar two's complement becomes offset binary
  function automatic logic [11:0] conv_code(input logic [11:0] code, input logic bipolar);
    logic [11:0] res;
    res = code;
    if (bipolar)
      res[ddoc_pkg::CODE_MSB] = ~code[ddoc_pkg::CODE_MSB];
    return res;
  endfunction

  // address decode to a channel select, used by bus path
  function automatic logic [1:0] chan_hit(input logic [7:0] addr);
    logic [1:0] hit;
    hit = 2'b00;
    if (addr == ddoc_pkg::ADDR_CH0_CODE)
      hit[0] = 1'b1;
    if (addr == ddoc_pkg::ADDR_CH1_CODE)
      hit[1] = 1'b1;
    return hit;
  endfunction

  ddoc_pkg::ddoc_mode_t mode_q;
  ddoc_pkg::ddoc_mode_t mode_d;
  logic trig_sync;
  logic trig_prev_q;
  logic trig_fall;
  logic update_evt;
  logic [2:0] ser_sync;
  logic ser_clk_prev_q;
  logic ser_frame_prev_q;
  logic ser_rise;
  logic ser_end;
  logic [15:0] ser_shift_q;
  logic [4:0] ser_cnt_q;
  logic ser_word_valid;
  ddoc_pkg::ddoc_word_t ser_word;
  logic [1:0] bus_hit;
  logic bus_write_ok;
  ddoc_pkg::ddoc_word_t bus_word;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  ddoc_pkg::ddoc_word_t fifo_out;
  logic [NCH-1:0] hold_pend_q;
  logic [CW-1:0] hold_code_q [NCH];
  logic [CW-1:0] out_code_q [NCH];
  logic [NCH-1:0] load_q;
  logic mode_change;

  // mode field decode into transfer method
  always_comb
  begin
    unique case (mode_field)
      ddoc_pkg::MODE_FIELD_FIFO: mode_d = ddoc_pkg::DDOC_FIFO;
      ddoc_pkg::MODE_FIELD_SER: mode_d = ddoc_pkg::DDOC_SER;
      default: mode_d = ddoc_pkg::DDOC_IMM;
    endcase
  end

  // registered method state
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      mode_q <= ddoc_pkg::DDOC_IMM;
    else
      mode_q <= mode_d;
  end

  assign mode_change = (mode_d != mode_q);
  assign mode_state = mode_q;

  // pin synchronisers: trigger, serial clock, data, frame
  ddoc_sync #(
    .W(1)
  ) u_trig_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(timer_trigger_n),
    .rst_val(1'b1),
    .pin_sync(trig_sync)
  );

  ddoc_sync #(
    .W(3)
  ) u_ser_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in({ser_frame_n, ser_data, ser_clk}),
    .rst_val(3'b100),
    .pin_sync(ser_sync)
  );

  // trigger falling edge from two successive synchronised samples
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      trig_prev_q <= 1'b1;
    else
      trig_prev_q <= trig_sync;
  end

  assign trig_fall = trig_prev_q && !trig_sync;

  // update event only matters outside immediate mode
  assign update_evt = (mode_q != ddoc_pkg::DDOC_IMM) && (trig_fall || update_strobe);

  // serial clock and frame edges
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ser_clk_prev_q <= 1'b0;
      ser_frame_prev_q <= 1'b1;
    end
    else
    begin
      ser_clk_prev_q <= ser_sync[0];
      ser_frame_prev_q <= ser_sync[2];
    end
  end

  assign ser_rise = ser_sync[0] && !ser_clk_prev_q && !ser_sync[2];
  assign ser_end = ser_sync[2] && !ser_frame_prev_q;

  // serial shift register, msb first, counts bits in the frame
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ser_shift_q <= 16'h0000;
      ser_cnt_q <= ddoc_pkg::SER_CNT_RST;
    end
    else if (ser_end)
    begin
      ser_cnt_q <= ddoc_pkg::SER_CNT_RST;
    end
    else if (ser_rise)
    begin
      ser_shift_q <= {ser_shift_q[14:0], ser_sync[1]};
      if (ser_cnt_q != ddoc_pkg::SER_CNT_FULL)
        ser_cnt_q <= ser_cnt_q + 5'h01;
    end
  end

  // a frame with sixteen or more bits yields one word, from its last sixteen bits
  assign ser_word_valid = ser_end && (ser_cnt_q == ddoc_pkg::SER_CNT_FULL)
                          && (mode_q == ddoc_pkg::DDOC_SER);
  assign ser_word.chan = ser_shift_q[ddoc_pkg::SER_CHAN_BIT];
  assign ser_word.code = ser_shift_q[CW-1:0];

  // bus decode: only full-word writes to a code register count
  assign bus_hit = chan_hit(bus_wr.addr);
  assign bus_write_ok = bus_wr.wr && bus_wr.word && (bus_hit != 2'b00);
  assign bus_word.chan = bus_hit[1];
  assign bus_word.code = bus_wr.data[ddoc_pkg::CODE_MSB:0];

  // fifo path only in fifo mode
  assign fifo_in_valid = bus_write_ok && (mode_q == ddoc_pkg::DDOC_FIFO);

  // bus stalls while the fifo is full in fifo mode
  assign bus_ready = (mode_q != ddoc_pkg::DDOC_FIFO) || fifo_in_ready;

  // fifo drains into a channel's hold slot once that slot is free
  assign fifo_out_ready = (mode_q == ddoc_pkg::DDOC_FIFO)
                          && !hold_pend_q[fifo_out.chan];

  ddoc_fifo #(
    .WIDTH($bits(ddoc_pkg::ddoc_word_t)),
    .DEPTH(ddoc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .flush(mode_change),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(bus_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // per-channel hold slot and converter output
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      logic fill_fifo;
      logic fill_ser;
      logic fill_imm;

      assign fill_fifo = fifo_out_valid && fifo_out_ready && (fifo_out.chan == ch);
      assign fill_ser = ser_word_valid && (ser_word.chan == ch);
      assign fill_imm = bus_write_ok && bus_hit[ch] && (mode_q == ddoc_pkg::DDOC_IMM);

      // hold slot: written from fifo or serial, emptied by update
      always_ff @(posedge core_clk)
      begin
        if (!rst_b || mode_change)
        begin
          hold_code_q[ch] <= ddoc_pkg::CODE_RST;
          hold_pend_q[ch] <= 1'b0;
        end
        else if (fill_fifo || fill_ser)
        begin
          hold_code_q[ch] <= fill_ser ? ser_word.code : fifo_out.code;
          hold_pend_q[ch] <= 1'b1; // new word wins over update clear
        end
        else if (update_evt)
        begin
          hold_pend_q[ch] <= 1'b0;
        end
      end

      // converter code register
      always_ff @(posedge core_clk)
      begin
        if (!rst_b)
        begin
          out_code_q[ch] <= ddoc_pkg::CODE_RST;
          load_q[ch] <= 1'b0;
        end
        else if (fill_imm)
        begin
          out_code_q[ch] <= bus_word.code;
          load_q[ch] <= 1'b1;
        end
        else if (update_evt && hold_pend_q[ch])
        begin
          out_code_q[ch] <= hold_code_q[ch];
          load_q[ch] <= 1'b1;
        end
        else
        begin
          load_q[ch] <= 1'b0;
        end
      end

      // polarity picks straight binary or offset binary output per channel
      assign dac_code[ch*CW +: CW] = conv_code(out_code_q[ch], ch_bipolar[ch]);
    end
  endgenerate

  assign dac_load = load_q;
  assign held_pending = hold_pend_q;

endmodule // ddoc_top

// *** dv/ddoc_props.sv ***
`timescale 1ns/1ps
// port-level checks of the converter output control
module ddoc_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire ddoc_pkg::ddoc_bus_wr_t bus_wr,
  input wire logic bus_ready,
  input wire logic [1:0] mode_field,
  input wire logic [1:0] ch_bipolar,
  input wire logic update_strobe,
  input wire logic timer_trigger_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_frame_n,
  input wire logic [23:0] dac_code,
  input wire logic [1:0] dac_load,
  input wire logic [1:0] held_pending,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic [2:0] mode_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // full-word channel 0 write in immediate mode
  sequence s_wr0;
    bus_wr.wr && bus_wr.word && bus_wr.addr == ddoc_pkg::ADDR_CH0_CODE
      && mode_state == ddoc_pkg::DDOC_IMM;
  endsequence
  // held code with no strobe, then a trigger fall in the next cycle
  sequence s_trig;
    held_pending[0] && !update_strobe ##1 $fell(timer_trigger_n);
  endsequence
  property p_imm_load;
    s_wr0 |=> dac_load[0];
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("no load after write");
  property p_uni;
    s_wr0 ##0 !ch_bipolar[0] |=> dac_code[11:0] == $past(bus_wr.data[11:0]);
  endproperty
  a_uni: assert property (p_uni) else $error("unipolar code wrong");
  property p_bip;
    s_wr0 ##0 ch_bipolar[0]
      |=> dac_code[11:0] == {~$past(bus_wr.data[11]), $past(bus_wr.data[10:0])};
  endproperty
  a_bip: assert property (p_bip) else $error("bipolar code wrong");
  property p_byte;
    mode_state == ddoc_pkg::DDOC_IMM && bus_wr.wr && !bus_wr.word |=> dac_load == 2'h0;
  endproperty
  a_byte: assert property (p_byte) else $error("byte write loaded");
  property p_strobe;
    held_pending[0] && update_strobe |=> dac_load[0];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe did not apply");
  property p_trig;
    s_trig |-> ##[1:5] dac_load[0];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not apply");
  property p_bypass;
    mode_state != ddoc_pkg::DDOC_FIFO && $past(mode_state) != ddoc_pkg::DDOC_FIFO |-> fifo_empty;
  endproperty
  a_bypass: assert property (p_bypass) else $error("fifo used");
  property p_ready;
    !bus_ready |-> mode_state == ddoc_pkg::DDOC_FIFO && fifo_full;
  endproperty
  a_ready: assert property (p_ready) else $error("refused wrongly");
  property p_mode;
    1'b1 |=> mode_state == ($past(mode_field) == ddoc_pkg::MODE_FIELD_FIFO ? ddoc_pkg::DDOC_FIFO :
      $past(mode_field) == ddoc_pkg::MODE_FIELD_SER ? ddoc_pkg::DDOC_SER : ddoc_pkg::DDOC_IMM);
  endproperty
  a_mode: assert property (p_mode) else $error("method wrong");
endmodule // ddoc_props

bind ddoc_top ddoc_props u_props (.core_clk, .rst_b, .bus_wr, .bus_ready, .mode_field,
  .ch_bipolar, .update_strobe, .timer_trigger_n, .ser_clk, .ser_data, .ser_frame_n,
  .dac_code, .dac_load, .held_pending, .fifo_full, .fifo_empty, .mode_state);

// *** dv/ddoc_host.sv ***
`timescale 1ns/1ps
// host on the local data bus
module ddoc_host (
  input wire logic core_clk,
  input wire logic bus_ready,
  output ddoc_pkg::ddoc_bus_wr_t bus_wr
);
  int miss = 0;
  initial bus_wr = '0;
  // write held until accepted, bounded
  task automatic put(input logic [7:0] a, input logic [15:0] d, input logic w);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    bus_wr <= '{wr: 1'b1, word: w, addr: a, data: d};
    // ready is settled one step after the edge and holds until the next one
    do
    begin
      #1;
      ok = (bus_ready === 1'b1);
      @(posedge core_clk);
      n++;
    end while (!ok && n < 40);
    if (!ok) miss++;
  endtask
  // released lines show the inverse of the last word
  task automatic idle();
    bus_wr <= '{wr: 1'b0, word: ~bus_wr.word, addr: ~bus_wr.addr, data: ~bus_wr.data};
  endtask
endmodule // ddoc_host

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// self-checking bench
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  ddoc_pkg::ddoc_bus_wr_t bus_wr;
  logic bus_ready, update_strobe, timer_trigger_n, ser_clk, ser_data, ser_frame_n;
  logic fifo_full, fifo_empty;
  logic [1:0] mode_field, ch_bipolar, dac_load, held_pending;
  logic [23:0] dac_code;
  logic [2:0] mode_state;
  logic [12:0] exp_q[$];
  logic [15:0] d;
  int err_total = 0;
  int checked = 0;
  // 40 mhz clock
  always #12.5 core_clk = ~core_clk;
  ddoc_host u_host (.core_clk, .bus_ready, .bus_wr);
  ddoc_top u_dut (.core_clk, .rst_b, .bus_wr, .bus_ready, .mode_field, .ch_bipolar,
    .update_strobe, .timer_trigger_n, .ser_clk, .ser_data, .ser_frame_n, .dac_code,
    .dac_load, .held_pending, .fifo_full, .fifo_empty, .mode_state);
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    err_total += u_host.miss;
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // converter form: bipolar msb inverted
  function automatic logic [12:0] conv(input logic c, input logic [11:0] v);
    return {c, v ^ {ch_bipolar[c], 11'h000}};
  endfunction
  // each load matched against the oldest note, sampled mid-cycle where settled
  always @(negedge core_clk)
    if (rst_b)
      for (int c = 0; c < 2; c++)
        if (dac_load[c] === 1'b1)
        begin
          if (exp_q.size() == 0)
            chk({c[0], dac_code[c*12 +: 12]}, ~{c[0], dac_code[c*12 +: 12]});
          else
            chk({c[0], dac_code[c*12 +: 12]}, exp_q.pop_front());
        end
  task automatic strobe();
    update_strobe <= 1'b1;
    @(posedge core_clk);
    update_strobe <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic trig();
    timer_trigger_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    timer_trigger_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  // bounded wait for a held code
  task automatic pend(input int c);
    int n;
    n = 0;
    while (held_pending[c] !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40)
    begin
      err_total++;
      end_of_test();
    end
  endtask
  // serial frame, msb first, clock idles low
  task automatic ser(input logic [15:0] w, input int nb);
    ser_frame_n <= 1'b0;
    for (int k = 0; k < nb; k++)
    begin
      ser_data <= w[15-k];
      repeat (4) @(posedge core_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    ser_frame_n <= 1'b1;
    ser_data <= ~ser_data;
    repeat (8) @(posedge core_clk);
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    mode_field <= ddoc_pkg::MODE_FIELD_IMM;
    ch_bipolar <= 2'h0;
    update_strobe <= 1'b0;
    timer_trigger_n <= 1'b1;
    ser_clk <= 1'b0;
    ser_data <= 1'b0;
    ser_frame_n <= 1'b1;
    void'($urandom(32'hf67952a0));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    // immediate writes back to back, each channel bipolar once
    for (int p = 1; p < 3; p++)
    begin
      ch_bipolar <= p[1:0];
      mode_field <= {p[1], p[1]}; // second pass uses the spare code, decoded as immediate
      @(posedge core_clk);
      for (int i = 0; i < 6; i++)
      begin
        d = (i == 0) ? 16'hf800 : 16'($urandom);
        u_host.put(i[0] ? ddoc_pkg::ADDR_CH1_CODE : ddoc_pkg::ADDR_CH0_CODE, d, 1'b1);
        exp_q.push_back(conv(i[0], d[11:0]));
      end
      u_host.idle();
      @(posedge core_clk);
    end
    // byte write and unmapped address
    u_host.put(ddoc_pkg::ADDR_CH0_CODE, 16'h0123, 1'b0);
    u_host.put(8'h14, 16'h0456, 1'b1);
    u_host.idle();
    mode_field <= ddoc_pkg::MODE_FIELD_FIFO;
    ch_bipolar <= 2'h0;
    repeat (3) @(posedge core_clk);
    // fill until refused, then drain by strobe and trigger
    for (int i = 0; i < 10; i++)
    begin
      if (i == 9)
      begin
        u_host.idle();
        repeat (2) @(posedge core_clk);
        chk({12'h000, fifo_full}, 13'h001);
        chk({12'h000, bus_ready}, 13'h000);
        strobe();
      end
      d = 16'($urandom);
      u_host.put(ddoc_pkg::ADDR_CH0_CODE, d, 1'b1);
      exp_q.push_back(conv(1'b0, d[11:0]));
    end
    u_host.idle();
    for (int i = 0; i < 9; i++)
    begin
      pend(0);
      if (i[0]) strobe();
      else trig();
    end
    chk({12'h000, fifo_empty}, 13'h001);
    mode_field <= ddoc_pkg::MODE_FIELD_SER;
    repeat (3) @(posedge core_clk);
    // serial: bus write ignored, short frame discarded
    u_host.put(ddoc_pkg::ADDR_CH0_CODE, 16'h0321, 1'b1);
    u_host.idle();
    ser(16'h1abc, 16);
    exp_q.push_back(conv(1'b1, 12'habc));
    pend(1);
    strobe();
    ser(16'h0555, 15);
    strobe();
    d = 16'($urandom);
    ser({4'h0, d[11:0]}, 16);
    exp_q.push_back(conv(1'b0, d[11:0]));
    pend(0);
    trig();
    chk(13'(exp_q.size()), 13'h000);
    end_of_test();
  end
endmodule // testbench
